// ### pkg/msm_defs.vh
// Constants for the memory select and mapping block
`ifndef MSM_DEFS_VH
`define MSM_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define MSM_CLK_PERIOD_NS   10
`define MSM_RST_TIME_NS     1000000
`define MSM_RST_CYCLES      (`MSM_RST_TIME_NS / `MSM_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Configuration space offsets (low address byte)
// ----------------------------------------------------------------
`define MSM_OFS_FLASH_PROT  8'hC0
`define MSM_OFS_EE_PROT     8'hC2
`define MSM_OFS_SPACE_MAP   8'hE0
`define MSM_OFS_PAGE        8'hF0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MSM_PAGE_RST        8'h00
`define MSM_SPACE_MAP_RST   8'h00
`define MSM_PROT_RST        8'h00

// ----------------------------------------------------------------
// Space map field positions
// ----------------------------------------------------------------
`define MSM_MAP_PERIPH_IO_ENABLE      7
`define MSM_MAP_FLASH_IN_DATA_SPACE     4
`define MSM_MAP_EEPROM_IN_DATA_SPACE     3
`define MSM_MAP_FLASH_IN_CODE_SPACE     2
`define MSM_MAP_EEPROM_IN_CODE_SPACE     1
`define MSM_MAP_SRAM_CODE   0

// ----------------------------------------------------------------
// Protection and security status layout
// ----------------------------------------------------------------
`define MSM_EE_SECURITY_BIT 7
`define MSM_EE_PROT_MSB     3

// ----------------------------------------------------------------
// Reset instruction codes
// ----------------------------------------------------------------
`define MSM_CMD_RESET       8'hF0
`define MSM_CMD_UNLOCK1     8'hAA
`define MSM_CMD_UNLOCK2     8'h55
`define MSM_ADR_UNLOCK1     12'h555
`define MSM_ADR_UNLOCK2     12'hAAA

// ----------------------------------------------------------------
// SRAM geometry
// ----------------------------------------------------------------
`define MSM_SRAM_DEPTH      2048
`define MSM_SRAM_AW         11

`endif

// ### verilog/msm_prio.v
// Space gating and priority resolution of memory selects
`include "msm_defs.vh"

module msm_prio (
    input  wire [7:0] fs_raw,
    input  wire [3:0] ees_raw,
    input  wire       rs_raw,
    input  wire       csio_raw,
    input  wire       pio_raw,
    input  wire       code_cyc,
    input  wire       data_cyc,
    input  wire [7:0] space_map,
    output reg  [7:0] fs_gnt,
    output reg  [3:0] ees_gnt,
    output reg        rs_gnt,
    output reg        csio_gnt,
    output reg        pio_gnt
);

    reg fl_ok;
    reg ee_ok;
    reg io_hit;
    reg ee_hit;

    always @* begin
        fl_ok = (code_cyc & space_map[`MSM_MAP_FLASH_IN_CODE_SPACE]) |
                (data_cyc & space_map[`MSM_MAP_FLASH_IN_DATA_SPACE]);
        ee_ok = (code_cyc & space_map[`MSM_MAP_EEPROM_IN_CODE_SPACE]) |
                (data_cyc & space_map[`MSM_MAP_EEPROM_IN_DATA_SPACE]);
        rs_gnt = rs_raw & ((code_cyc & space_map[`MSM_MAP_SRAM_CODE]) |
                 data_cyc);
        csio_gnt = csio_raw & data_cyc;
        pio_gnt = pio_raw & data_cyc & space_map[`MSM_MAP_PERIPH_IO_ENABLE];
        io_hit = rs_gnt | csio_gnt | pio_gnt;
        ee_hit = ee_ok & (|ees_raw);
        // Level one: SRAM and I/O take the address from any sector
        ees_gnt = (ee_ok & ~io_hit) ? ees_raw : 4'h0;
        // Level two: EEPROM shadows an overlapping flash sector
        fs_gnt = (fl_ok & ~io_hit & ~ee_hit) ? fs_raw : 8'h00;
    end

endmodule

// ### verilog/msm_sram.v
// Internal battery-backed SRAM, bytes addressed by the low bits
`include "msm_defs.vh"

module msm_sram #(
    parameter DEPTH = `MSM_SRAM_DEPTH,
    parameter AW    = `MSM_SRAM_AW
) (
    input  wire          clk,
    input  wire          en,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wdata,
    output reg  [7:0]    rdata
);

    reg [7:0] mem [0:DEPTH-1];

    // ------------------------------------------------------------
    // Array access, only while selected
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end

endmodule

// ### verilog/msm_top.v
// Memory select, protection, space mapping and page register block
`include "msm_defs.vh"

module msm_top #(
    parameter       RST_CYCLES    = `MSM_RST_CYCLES,
    parameter       RST_CNT_W     = 17,
    parameter [7:0] SPACE_MAP_INIT = `MSM_SPACE_MAP_RST
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire [15:0] mcu_addr,
    input  wire [7:0]  mcu_data_in,
    output reg  [7:0]  mcu_data_out,
    output reg         mcu_data_oe,
    input  wire        mcu_wr_n,
    input  wire        mcu_rd_n,
    input  wire        mcu_psen_n,
    input  wire [7:0]  flash_sector_select,
    input  wire [3:0]  eeprom_sector_select,
    input  wire        sram_select,
    input  wire        config_io_select,
    input  wire        periph_io_select,
    input  wire        prot_load,
    input  wire [7:0]  prot_flash_in,
    input  wire [3:0]  prot_eeprom_in,
    input  wire        security_set_in,
    input  wire        standby_supply_input,
    input  wire        battery_on_enable,
    output reg         battery_on_flag,
    output wire [7:0]  page_bits,
    output reg  [7:0]  flash_sel,
    output reg  [3:0]  eeprom_sel,
    output reg         periph_io_enable,
    output reg         mem_rd,
    input  wire [7:0]  mem_rdata,
    output reg         mem_wr_pulse,
    output reg  [15:0] mem_wr_addr,
    output reg  [7:0]  mem_wr_data,
    output reg         mem_reset_busy,
    output reg         mem_reset_pulse
);

    // ------------------------------------------------------------
    // Local constants and state codes
    // ------------------------------------------------------------
    localparam SW = 43;
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_ULK1  = 4'b0010;
    localparam [3:0] ST_ULK2  = 4'b0100;
    localparam [3:0] ST_BUSY  = 4'b1000;
    localparam [31:0] RST_LAST = RST_CYCLES - 1;

    function is_ofs;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            is_ofs = (adr == ofs);
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and strobe edge
    // ------------------------------------------------------------
    wire [SW-1:0] pin_vec;
    reg  [SW-1:0] sync1_ff;
    reg  [SW-1:0] sync2_ff;
    assign pin_vec = {standby_supply_input, periph_io_select,
                      config_io_select, sram_select,
                      eeprom_sector_select, flash_sector_select,
                      mcu_psen_n, mcu_rd_n, mcu_wr_n,
                      mcu_data_in, mcu_addr};
    // Strobes reset to their released level, so no false edge follows
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= {{16{1'b0}}, 3'b111, {24{1'b0}}};
            sync2_ff <= {{16{1'b0}}, 3'b111, {24{1'b0}}};
        end else begin
            sync1_ff <= pin_vec;
            sync2_ff <= sync1_ff;
        end
    end

    wire [15:0] s_addr  = sync2_ff[15:0];
    wire [7:0]  s_data  = sync2_ff[23:16];
    wire        s_wr    = ~sync2_ff[24];
    wire        s_rd    = ~sync2_ff[25];
    wire        s_psen  = ~sync2_ff[26];
    wire [7:0]  s_fs    = sync2_ff[34:27];
    wire [3:0]  s_ees   = sync2_ff[38:35];
    wire        s_rs    = sync2_ff[39];
    wire        s_csio  = sync2_ff[40];
    wire        s_pio   = sync2_ff[41];
    wire        s_vbat  = sync2_ff[42];

    reg  wr_d_ff;
    wire wr_end;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_d_ff <= 1'b0;
        end else begin
            wr_d_ff <= s_wr;
        end
    end

    // Writes act once, when the strobe is released
    assign wr_end = wr_d_ff & ~s_wr;

    reg [7:0] page_ff;
    reg [7:0] map_ff;
    reg [7:0] fl_prot_ff;
    reg [3:0] ee_prot_ff;
    reg       secure_ff;
    reg [7:0] nxt_page;
    reg [7:0] nxt_map;

    assign page_bits = page_ff;

    wire [7:0] fs_gnt;
    wire [3:0] ees_gnt;
    wire       rs_gnt;
    wire       csio_gnt;
    wire       pio_gnt;
    wire       data_cyc = s_rd | s_wr | wr_d_ff;

    msm_prio u_prio (
        .fs_raw    (s_fs),
        .ees_raw   (s_ees),
        .rs_raw    (s_rs),
        .csio_raw  (s_csio),
        .pio_raw   (s_pio),
        .code_cyc  (s_psen),
        .data_cyc  (data_cyc),
        .space_map (map_ff),
        .fs_gnt    (fs_gnt),
        .ees_gnt   (ees_gnt),
        .rs_gnt    (rs_gnt),
        .csio_gnt  (csio_gnt),
        .pio_gnt   (pio_gnt)
    );

    wire cfg_wr = wr_end & csio_gnt;

    always @* begin
        nxt_page = page_ff;
        nxt_map = map_ff;
        if (cfg_wr && is_ofs(s_addr[7:0], `MSM_OFS_PAGE)) begin
            nxt_page = s_data;
        end
        if (cfg_wr && is_ofs(s_addr[7:0], `MSM_OFS_SPACE_MAP)) begin
            nxt_map = s_data;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            page_ff <= `MSM_PAGE_RST;
            map_ff <= SPACE_MAP_INIT;
        end else begin
            page_ff <= nxt_page;
            map_ff <= nxt_map;
        end
    end

    // Protection changes only through the programming path
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fl_prot_ff <= `MSM_PROT_RST;
            ee_prot_ff <= 4'h0;
            secure_ff <= 1'b0;
        end else if (prot_load) begin
            fl_prot_ff <= prot_flash_in;
            ee_prot_ff <= prot_eeprom_in;
            secure_ff <= security_set_in;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    wire [7:0] sram_rdata;
    wire       sram_en = rs_gnt & (s_rd | s_psen | wr_end);
    reg  [7:0] cfg_rdata;
    reg        rs_rd_ff;

    msm_sram u_sram (
        .clk   (clk),
        .en    (sram_en),
        .we    (wr_end),
        .addr  (s_addr[`MSM_SRAM_AW-1:0]),
        .wdata (s_data),
        .rdata (sram_rdata)
    );

    always @* begin
        cfg_rdata = 8'h00;
        if (is_ofs(s_addr[7:0], `MSM_OFS_PAGE)) begin
            cfg_rdata = page_ff;
        end else if (is_ofs(s_addr[7:0], `MSM_OFS_SPACE_MAP)) begin
            cfg_rdata = map_ff;
        end else if (is_ofs(s_addr[7:0], `MSM_OFS_FLASH_PROT)) begin
            cfg_rdata = fl_prot_ff;
        end else if (is_ofs(s_addr[7:0], `MSM_OFS_EE_PROT)) begin
            cfg_rdata = {secure_ff, 3'b000, ee_prot_ff};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs_rd_ff <= 1'b0;
            mcu_data_oe <= 1'b0;
            mcu_data_out <= 8'h00;
            flash_sel <= 8'h00;
            eeprom_sel <= 4'h0;
            periph_io_enable <= 1'b0;
            mem_rd <= 1'b0;
        end else begin
            rs_rd_ff <= rs_gnt & (s_rd | s_psen);
            flash_sel <= fs_gnt;
            eeprom_sel <= ees_gnt;
            periph_io_enable <= pio_gnt;
            // Protected sectors read the same as open ones
            mem_rd <= (|fs_gnt | |ees_gnt) & (s_rd | s_psen);
            mcu_data_oe <= (s_rd | s_psen) &
                           (rs_gnt | csio_gnt | |fs_gnt | |ees_gnt);
            if (rs_rd_ff) begin
                mcu_data_out <= sram_rdata;
            end else if (csio_gnt & s_rd) begin
                mcu_data_out <= cfg_rdata;
            end else if (mem_rd) begin
                mcu_data_out <= mem_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Program and erase write filter
    // ------------------------------------------------------------
    wire [7:0] fl_hit;
    wire [3:0] ee_hit;
    wire       mem_wr = wr_end & (|fs_gnt | |ees_gnt);
    wire       locked;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_fl
            assign fl_hit[gi] = fs_gnt[gi] & fl_prot_ff[gi];
        end
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ee
            assign ee_hit[gi] = ees_gnt[gi] & ee_prot_ff[gi];
        end
    endgenerate

    assign locked = |fl_hit | |ee_hit;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_wr_pulse <= 1'b0;
            mem_wr_addr <= 16'h0000;
            mem_wr_data <= 8'h00;
        end else begin
            mem_wr_pulse <= mem_wr & ~locked & ~mem_reset_busy;
            if (mem_wr & ~locked) begin
                mem_wr_addr <= s_addr;
                mem_wr_data <= s_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Reset instruction sequencer
    // ------------------------------------------------------------
    reg [3:0]           st_ff;
    reg [3:0]           nxt_st;
    reg [RST_CNT_W-1:0] cnt_ff;
    reg [RST_CNT_W-1:0] nxt_cnt;
    wire a_ulk1 = (s_addr[11:0] == `MSM_ADR_UNLOCK1);
    wire a_ulk2 = (s_addr[11:0] == `MSM_ADR_UNLOCK2);
    wire d_rst  = (s_data == `MSM_CMD_RESET);

    always @* begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            ST_IDLE: begin
                if (mem_wr && d_rst) begin
                    nxt_st = ST_BUSY;
                    nxt_cnt = {RST_CNT_W{1'b0}};
                end else if (mem_wr && a_ulk1 &&
                             s_data == `MSM_CMD_UNLOCK1) begin
                    nxt_st = ST_ULK1;
                end
            end
            ST_ULK1: begin
                if (mem_wr) begin
                    nxt_st = (a_ulk2 && s_data == `MSM_CMD_UNLOCK2) ?
                             ST_ULK2 : ST_IDLE;
                end
            end
            ST_ULK2: begin
                if (mem_wr) begin
                    nxt_st = (a_ulk1 && d_rst) ? ST_BUSY : ST_IDLE;
                    nxt_cnt = {RST_CNT_W{1'b0}};
                end
            end
            ST_BUSY: begin
                if (cnt_ff == RST_LAST[RST_CNT_W-1:0]) begin
                    nxt_st = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff + {{(RST_CNT_W-1){1'b0}}, 1'b1};
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= ST_IDLE;
            cnt_ff <= {RST_CNT_W{1'b0}};
            mem_reset_busy <= 1'b0;
            mem_reset_pulse <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            mem_reset_busy <= (nxt_st == ST_BUSY);
            mem_reset_pulse <= (nxt_st == ST_BUSY) & (st_ff != ST_BUSY);
        end
    end

    // ------------------------------------------------------------
    // Battery indicator
    // ------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            battery_on_flag <= 1'b0;
        end else begin
            battery_on_flag <= battery_on_enable & s_vbat;
        end
    end

endmodule

// ### verification/msm_mcu_model.sv
// Microcontroller bus model: address, data, strobes and decoder selects
module msm_mcu_model (
    input  wire logic   clk,
    output logic [15:0] mcu_addr,
    output logic [7:0]  mcu_data_in,
    output logic        mcu_wr_n,
    output logic        mcu_rd_n,
    output logic        mcu_psen_n,
    output logic [14:0] sel
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        mcu_addr = 16'h0000;
        mcu_data_in = 8'h00;
        {mcu_wr_n, mcu_rd_n, mcu_psen_n} = 3'b111;
        sel = 15'h0000;
    end

    // One bus cycle: 0 write, 1 data read, 2 code fetch
    task automatic cycle(input logic [1:0] kind, input logic [15:0] a,
                         input logic [7:0] d, input logic [14:0] s);
        @(negedge clk);
        mcu_addr = a;
        mcu_data_in = d;
        sel = s;
        repeat (3) @(negedge clk);
        mcu_wr_n = (kind != 2'd0);
        mcu_rd_n = (kind != 2'd1);
        mcu_psen_n = (kind != 2'd2);
        repeat (8) @(negedge clk);
        {mcu_wr_n, mcu_rd_n, mcu_psen_n} = 3'b111;
        repeat (2) @(negedge clk);
        // Released address and data show the inverse of the last value; selects clear
        mcu_addr = ~a;
        mcu_data_in = ~d;
        sel = 15'h0000;
        repeat (4) @(negedge clk);
    endtask
endmodule

// ### verification/msm_top_sva.sv
// Port-level assertions for the memory select and mapping block
module msm_top_sva #(
    parameter RST_CYCLES = 40
) (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       mcu_wr_n,
    input wire logic       mcu_rd_n,
    input wire logic       mcu_psen_n,
    input wire logic       mcu_data_oe,
    input wire logic       battery_on_enable,
    input wire logic       battery_on_flag,
    input wire logic [7:0] page_bits,
    input wire logic [7:0] flash_sel,
    input wire logic [3:0] eeprom_sel,
    input wire logic       periph_io_enable,
    input wire logic       mem_wr_pulse,
    input wire logic       mem_reset_busy,
    input wire logic       mem_reset_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  wr_age_ff;
    logic [3:0]  rd_age_ff;
    logic [31:0] busy_cnt_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Cycles since the last strobes, and length of the reset wait
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_age_ff <= 4'hf;
            rd_age_ff <= 4'hf;
            busy_cnt_ff <= 32'h0000_0000;
        end else begin
            if (!mcu_wr_n) wr_age_ff <= 4'h0;
            else if (wr_age_ff != 4'hf) wr_age_ff <= wr_age_ff + 4'h1;
            if (!mcu_rd_n || !mcu_psen_n) rd_age_ff <= 4'h0;
            else if (rd_age_ff != 4'hf) rd_age_ff <= rd_age_ff + 4'h1;
            busy_cnt_ff <= mem_reset_busy ? busy_cnt_ff + 32'h1 : 32'h0;
        end
    end

    property p_page_rst;
        $rose(arst_n) |-> page_bits == 8'h00;
    endproperty
    a_page_rst: assert property (p_page_rst)
        else $error("page not clear");
    property p_page_cause;
        $changed(page_bits) |-> wr_age_ff < 4'h8;
    endproperty
    a_page_cause: assert property (p_page_cause)
        else $error("page moved without write");
    property p_wr_cause;
        mem_wr_pulse |-> wr_age_ff < 4'h8 && !$past(mem_reset_busy);
    endproperty
    a_wr_cause: assert property (p_wr_cause)
        else $error("stray memory write");
    property p_rst_pulse;
        mem_reset_pulse |=> mem_reset_busy;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset wait not entered");
    property p_rst_len;
        $fell(mem_reset_busy) |-> busy_cnt_ff == RST_CYCLES;
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset wait length wrong");
    property p_ee_win;
        |eeprom_sel |-> flash_sel == 8'h00;
    endproperty
    a_ee_win: assert property (p_ee_win)
        else $error("flash granted beside eeprom");
    property p_io_win;
        periph_io_enable |-> flash_sel == 8'h00 && eeprom_sel == 4'h0;
    endproperty
    a_io_win: assert property (p_io_win)
        else $error("memory granted beside io");
    property p_oe_cause;
        mcu_data_oe |-> rd_age_ff < 4'h8;
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("data driven without read");
    property p_bat;
        !$past(battery_on_enable) |-> !battery_on_flag;
    endproperty
    a_bat: assert property (p_bat)
        else $error("battery flag while disabled");
endmodule

bind msm_top msm_top_sva #(.RST_CYCLES(RST_CYCLES)) u_sva (
    .clk(clk), .arst_n(arst_n), .mcu_wr_n(mcu_wr_n),
    .mcu_rd_n(mcu_rd_n), .mcu_psen_n(mcu_psen_n),
    .mcu_data_oe(mcu_data_oe), .battery_on_enable(battery_on_enable),
    .battery_on_flag(battery_on_flag), .page_bits(page_bits),
    .flash_sel(flash_sel), .eeprom_sel(eeprom_sel),
    .periph_io_enable(periph_io_enable), .mem_wr_pulse(mem_wr_pulse),
    .mem_reset_busy(mem_reset_busy), .mem_reset_pulse(mem_reset_pulse)
);

// ### verification/testbench.sv
// Self-checking bench for the memory select and mapping block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RST_N = 40;
    localparam logic [14:0] CFG = 15'h0002;
    localparam logic [14:0] SRM = 15'h0004;
    logic        clk = 1'b0;
    logic        arst_n, prot_load, sec_in, stby, bat_en, ign_wr, mrd;
    logic        wr_n, rd_n, psen_n, oe, bat_flag, pio, wr_pulse, busy, rp;
    logic        oe_q = 1'b0;
    logic [15:0] mcu_addr, wr_addr;
    logic [7:0]  data_in, data_out, page_bits, flash_sel, wr_data, v, last_q;
    logic [7:0]  prot_f, mem_rdata;
    logic [3:0]  prot_e, ee_sel;
    logic [14:0] sel;
    logic [7:0]  rq[$];
    logic [23:0] wq[$];
    int          n_mismatch = 0, compares = 0, n_rst = 0, i;
    int          seed = 32'ha6a1_5da5;
    // Map value, select set, expected byte; bit i of cd set for fetches
    logic [7:0]  mp[9] = '{8'h0C, 8'h14, 8'h14, 8'h02, 8'h04, 8'h05,
                           8'h04, 8'h08, 8'h10};
    logic [14:0] sl[9] = '{15'h0200, 15'h0200, 15'h0200, 15'h0210, 15'h0210,
                           15'h0204, 15'h0204, 15'h0210, 15'h0210};
    logic [7:0]  ex[9] = '{8'h04, 8'h04, 8'h04, 8'h20, 8'h04, 8'h5A, 8'h04,
                           8'h20, 8'h04};
    logic [8:0]  cd = 9'h07b;

    always #5 clk = ~clk;
    assign mem_rdata = mrd ? (flash_sel | {ee_sel, 4'h0}) : 8'h00;

    msm_mcu_model m (
        .clk(clk), .mcu_addr(mcu_addr), .mcu_data_in(data_in),
        .mcu_wr_n(wr_n), .mcu_rd_n(rd_n), .mcu_psen_n(psen_n), .sel(sel)
    );

    msm_top #(.RST_CYCLES(RST_N)) DUT (
        .clk(clk), .arst_n(arst_n), .mcu_addr(mcu_addr),
        .mcu_data_in(data_in), .mcu_data_out(data_out), .mcu_data_oe(oe),
        .mcu_wr_n(wr_n), .mcu_rd_n(rd_n), .mcu_psen_n(psen_n),
        .flash_sector_select(sel[14:7]), .eeprom_sector_select(sel[6:3]),
        .sram_select(sel[2]), .config_io_select(sel[1]),
        .periph_io_select(sel[0]), .prot_load(prot_load),
        .prot_flash_in(prot_f), .prot_eeprom_in(prot_e),
        .security_set_in(sec_in), .standby_supply_input(stby),
        .battery_on_enable(bat_en), .battery_on_flag(bat_flag),
        .page_bits(page_bits), .flash_sel(flash_sel), .eeprom_sel(ee_sel),
        .periph_io_enable(pio), .mem_rd(mrd), .mem_rdata(mem_rdata),
        .mem_wr_pulse(wr_pulse), .mem_wr_addr(wr_addr),
        .mem_wr_data(wr_data), .mem_reset_busy(busy), .mem_reset_pulse(rp)
    );

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [14:0] s,
                      input logic [7:0] e, input logic code);
        rq.push_back(e);
        m.cycle(code ? 2'd2 : 2'd1, a, 8'h00, s);
    endtask

    task automatic wr(input logic [15:0] a, input logic [14:0] s,
                      input logic [7:0] d, input logic mem);
        if (mem) wq.push_back({a, d});
        m.cycle(2'd0, a, d, s);
    endtask

    task automatic prot(input logic [7:0] f, input logic [3:0] e,
                        input logic s);
        @(negedge clk);
        prot_load = 1'b1;
        prot_f = f;
        prot_e = e;
        sec_in = s;
        @(negedge clk);
        prot_load = 1'b0;
    endtask

    task automatic wait_idle();
        int k = 0;
        while (busy !== 1'b0 && k < 200) begin
            @(negedge clk);
            k++;
        end
        if (k == 200) begin
            check(24'h1, 24'h0);
            test_done();
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Results are matched to the oldest note: reads when the output enable falls, writes on the pulse
    always @(posedge clk) begin
        oe_q <= oe;
        if (oe === 1'b1) last_q <= data_out;
        if (rp === 1'b1) n_rst <= n_rst + 1;
        if (oe_q === 1'b1 && oe === 1'b0) begin
            if (rq.size() == 0) check(24'h1, 24'h0);
            else check(24'(last_q), 24'(rq.pop_front()));
        end
        if (wr_pulse === 1'b1 && !ign_wr) begin
            if (wq.size() == 0) check(24'h1, 24'h0);
            else check({wr_addr, wr_data}, wq.pop_front());
        end
    end

    initial begin
        {arst_n, prot_load, sec_in, stby, bat_en, ign_wr} = 6'h00;
        prot_f = 8'h00;
        prot_e = 4'h0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        rd(16'hB0F0, CFG, 8'h00, 1'b0);
        rd(16'hB0E0, CFG, 8'h00, 1'b0);
        rd(16'hB0C2, CFG, 8'h00, 1'b0);
        v = 8'($random(seed));
        wr(16'hB0F0, CFG, v, 1'b0);
        rd(16'hB0F0, CFG, v, 1'b0);
        check(24'(page_bits), 24'(v));
        wr(16'hB0D4, CFG, 8'h5A, 1'b0);
        rd(16'hB0D4, CFG, 8'h00, 1'b0);
        v = 8'($random(seed));
        prot(v, v[7:4], 1'b1);
        rd(16'hB0C0, CFG, v, 1'b0);
        rd(16'hB0C2, CFG, {4'h8, v[7:4]}, 1'b0);
        wr(16'hB0C0, CFG, ~v, 1'b0);
        rd(16'hB0C0, CFG, v, 1'b0);
        prot(8'h08, 4'h2, 1'b0);
        rd(16'hB0C2, CFG, 8'h02, 1'b0);
        wr(16'hB0E0, CFG, 8'h1C, 1'b0);
        wr(16'h4123, 15'h0200, 8'h3C, 1'b1);
        wr(16'h4321, 15'h0400, 8'hC3, 1'b0);
        wr(16'h2222, 15'h0010, 8'h11, 1'b0);
        wr(16'h2001, 15'h0008, 8'h22, 1'b1);
        rd(16'h4321, 15'h0400, 8'h08, 1'b0);
        rd(16'h8000, 15'h0090, 8'h20, 1'b0);
        v = 8'($random(seed));
        wr(16'h87FF, SRM, 8'h5A, 1'b0);
        wr(16'h8000, SRM, v, 1'b0);
        rd(16'h87FF, SRM, 8'h5A, 1'b0);
        rd(16'h8000, 15'h0094, v, 1'b0);
        wr(16'h8000, 15'h0080, 8'hEE, 1'b1);
        rd(16'h8000, SRM, v, 1'b0);
        wr(16'hB0E0, CFG, 8'h9C, 1'b0);
        wr(16'h8100, 15'h0081, 8'h33, 1'b0);
        for (i = 0; i < 9; i++) begin
            wr(16'hB0E0, CFG, mp[i], 1'b0);
            rd(16'h87FF, sl[i], ex[i], cd[i]);
        end
        ign_wr = 1'b1;
        wr(16'h4000, 15'h0200, 8'hF0, 1'b0);
        ign_wr = 1'b0;
        wr(16'h4001, 15'h0200, 8'h77, 1'b0);
        wait_idle();
        check(24'(n_rst), 24'h1);
        ign_wr = 1'b1;
        wr(16'h4555, 15'h0200, 8'hAA, 1'b0);
        wr(16'h4AAA, 15'h0200, 8'h55, 1'b0);
        wr(16'h4555, 15'h0200, 8'hF0, 1'b0);
        wait_idle();
        ign_wr = 1'b0;
        check(24'(n_rst), 24'h2);
        {bat_en, stby} = 2'b11;
        repeat (6) @(negedge clk);
        check(24'(bat_flag), 24'h1);
        stby = 1'b0;
        repeat (6) @(negedge clk);
        check(24'(bat_flag), 24'h0);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        rd(16'hB0F0, CFG, 8'h00, 1'b0);
        check(24'(rq.size() + wq.size()), 24'h0);
        test_done();
    end
endmodule
